// file: logic/epe_regs.vh
// constants for the encoder pulse emulation block
`ifndef EPE_REGS_VH
`define EPE_REGS_VH

// register indices, one word each, byte address is four times the index
`define EPE_IDX_PULSES      4'h0
`define EPE_IDX_CONFIG      4'h1
`define EPE_IDX_MONSEL      4'h2
`define EPE_IDX_POSITION    4'h3
`define EPE_IDX_STATUS      4'h4
`define EPE_IDX_TORQUE      4'h5
`define EPE_IDX_OVERRIDE    4'h6
`define EPE_IDX_MONITOR     4'h7

// config field positions
`define EPE_CFG_PHASE_REV   0
`define EPE_CFG_SERIAL_232  1
`define EPE_CFG_TL_AVAIL    2

// reset values
`define EPE_RST_PULSES      16'h0FA0
`define EPE_RST_CONFIG      3'h0
`define EPE_RST_MONSEL      4'h0

// zero pulse least width
`define EPE_ZP_WIDTH_US     400
`define EPE_CLK_MHZ         125
`define EPE_ZP_CYCLES       (`EPE_ZP_WIDTH_US * `EPE_CLK_MHZ)

`endif

// file: logic/epe_zero_stretch.v
// zero pulse stretcher holding a revolution marker for a least width
`timescale 1ns/1ps
`default_nettype none

module epe_zero_stretch #(
    parameter CYCLES = 50000
) (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire clk_en_i,
    // marker in, stretched pulse out
    input wire mark_i,
    output reg pulse_o
);

    reg [31:0] cnt_q;

    // restart the width on each marker so close markers merge into one pulse
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q <= 32'h0;
            pulse_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (mark_i)
            begin
                cnt_q <= CYCLES - 1;
                pulse_o <= 1'b1;
            end
            else if (cnt_q != 32'h0)
                cnt_q <= cnt_q - 32'h1;
            else
                pulse_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: logic/epe_core.v
// encoder pulse emulation: quadrature, zero pulse, analog codes, serial select
`timescale 1ns/1ps
`default_nettype none
`include "epe_regs.vh"

module epe_core #(
    parameter POS_W = 24,
    parameter COUNTS_PER_REV = 24'h040000,
    parameter ZP_CYCLES = `EPE_ZP_CYCLES
) (
    // clock, enable, reset
    input wire sys_clk_i,
    input wire clk_en_i,
    input wire rst_b_i,
    // register port
    input wire [3:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    // motor position feedback, one count step per strobe
    input wire pos_step_i,
    input wire pos_dir_ccw_i,
    // quantities offered to the monitors
    input wire [9:0] speed_code_i,
    input wire [9:0] torque_code_i,
    input wire [9:0] current_code_i,
    input wire [9:0] droop_code_i,
    // analog input converter codes, two's complement for override
    input wire [9:0] analog_torque_limit_in_i,
    input wire signed [9:0] speed_override_in_i,
    input wire ext_torque_limit_select_i,
    // encoder outputs
    output reg phase_a_pos_o,
    output reg phase_a_neg_o,
    output reg phase_b_pos_o,
    output reg phase_b_neg_o,
    output reg zero_pulse_open_collector_b_o,
    output reg zero_pulse_diff_pos_o,
    output reg zero_pulse_diff_neg_o,
    // monitor codes to the converters
    output reg [9:0] monitor_out_one_o,
    output reg [9:0] monitor_out_two_o,
    // applied limits
    output reg [9:0] torque_limit_o,
    output reg [7:0] override_pct_o,
    // serial interface enables
    output reg serial_422_en_o,
    output reg serial_232_en_o
);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;
    // position wrap points held at the counter width
    localparam [POS_W-1:0] CPR = COUNTS_PER_REV;
    localparam [POS_W-1:0] CPR_LAST = CPR - {{(POS_W-1){1'b0}}, 1'b1};

    // register file
    reg [15:0] pulses_q;
    reg [2:0] cfg_q;
    reg [3:0] monsel_q;

    // position and quadrature state
    reg [POS_W-1:0] pos_q;
    reg [POS_W+17:0] acc_q;
    reg [1:0] quad_q;
    reg rev_mark_q;
    reg st_q;
    reg [31:0] rdata_d;
    reg [1:0] quad_d;
    reg [POS_W+17:0] acc_d;
    reg [POS_W+17:0] quarter_scale;
    wire zero_pulse;
    wire wr_pulses;
    wire wr_cfg;
    wire wr_mon;
    wire b_lags_a_now;
    reg signed [17:0] ovr_prod;
    reg signed [17:0] ovr_scaled;

    // pick one of four quantities for a monitor channel
    function [9:0] mon_pick;
        input [1:0] sel;
        input [9:0] s0;
        input [9:0] s1;
        input [9:0] s2;
        input [9:0] s3;
        begin
            case (sel)
                2'h0: mon_pick = s0;
                2'h1: mon_pick = s1;
                2'h2: mon_pick = s2;
                default: mon_pick = s3;
            endcase
        end
    endfunction

    // true when the write strobe addresses the given register index
    function wr_hit;
        input wr;
        input [3:0] addr;
        input [3:0] idx;
        begin
            wr_hit = wr && (addr == idx);
        end
    endfunction

    assign wr_pulses = wr_hit(reg_wr_i, reg_addr_i, `EPE_IDX_PULSES);
    assign wr_cfg = wr_hit(reg_wr_i, reg_addr_i, `EPE_IDX_CONFIG);
    assign wr_mon = wr_hit(reg_wr_i, reg_addr_i, `EPE_IDX_MONSEL);

    // software writes
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pulses_q <= `EPE_RST_PULSES;
            cfg_q <= `EPE_RST_CONFIG;
            monsel_q <= `EPE_RST_MONSEL;
        end
        else if (clk_en_i)
        begin
            if (wr_pulses)
                pulses_q <= reg_wdata_i[15:0];
            if (wr_cfg)
                cfg_q <= reg_wdata_i[2:0];
            if (wr_mon)
                monsel_q <= reg_wdata_i[3:0];
        end
    end

    // quarter-pulse steps: each ccw position count adds 4*pulses to the
    // accumulator and a quadrature edge is due when it reaches counts/rev;
    // assumes no more than one edge per count, i.e. 4*pulses <= counts/rev
    always @*
    begin
        quarter_scale = {{(POS_W+2){1'b0}}, pulses_q} << 2;
        acc_d = acc_q;
        quad_d = quad_q;
        if (pos_step_i)
        begin
            if (pos_dir_ccw_i)
            begin
                acc_d = acc_q + quarter_scale;
                if (acc_d >= {18'h0, CPR})
                begin
                    acc_d = acc_d - {18'h0, CPR};
                    quad_d = {quad_q[0], ~quad_q[1]}; // gray step forward
                end
            end
            else
            begin
                if (acc_q < quarter_scale)
                begin
                    acc_d = acc_q + {18'h0, CPR} - quarter_scale;
                    quad_d = {~quad_q[0], quad_q[1]}; // gray step back
                end
                else
                    acc_d = acc_q - quarter_scale;
            end
        end
    end

    // position counter, revolution marker and a small run/idle tracker
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pos_q <= {POS_W{1'b0}};
            acc_q <= {(POS_W+18){1'b0}};
            quad_q <= 2'h0;
            rev_mark_q <= 1'b0;
            st_q <= ST_IDLE;
        end
        else if (clk_en_i)
        begin
            rev_mark_q <= 1'b0;
            acc_q <= acc_d;
            quad_q <= quad_d;
            case (st_q)
                ST_IDLE:
                    if (pos_step_i)
                        st_q <= ST_RUN;
                ST_RUN:
                    if (!pos_step_i)
                        st_q <= ST_IDLE;
                default:
                    st_q <= ST_IDLE;
            endcase
            if (pos_step_i)
            begin
                if (pos_dir_ccw_i)
                begin
                    if (pos_q == CPR_LAST)
                    begin
                        pos_q <= {POS_W{1'b0}};
                        rev_mark_q <= 1'b1; // zero crossed once per turn
                    end
                    else
                        pos_q <= pos_q + 1'b1;
                end
                else
                begin
                    if (pos_q == {POS_W{1'b0}})
                    begin
                        pos_q <= CPR_LAST;
                        rev_mark_q <= 1'b1;
                    end
                    else
                        pos_q <= pos_q - 1'b1;
                end
            end
        end
    end

    // stretcher keeps the marker visible at low speed
    epe_zero_stretch #(
        .CYCLES(ZP_CYCLES)
    ) u_zero (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .mark_i(rev_mark_q),
        .pulse_o(zero_pulse)
    );

    // ccw gray steps raise bit 0 first, so bit 0 drives A and B lags;
    // the reverse bit swaps the phases
    assign b_lags_a_now = ~cfg_q[`EPE_CFG_PHASE_REV];

    // override scaling kept signed and wide so -512 really reaches zero
    always @*
    begin
        ovr_prod = speed_override_in_i * 18'sh00064;
        ovr_scaled = ovr_prod >>> 9;
    end

    // registered encoder and analog outputs
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            phase_a_pos_o <= 1'b0;
            phase_a_neg_o <= 1'b1;
            phase_b_pos_o <= 1'b0;
            phase_b_neg_o <= 1'b1;
            zero_pulse_open_collector_b_o <= 1'b1;
            zero_pulse_diff_pos_o <= 1'b0;
            zero_pulse_diff_neg_o <= 1'b1;
            monitor_out_one_o <= 10'h000;
            monitor_out_two_o <= 10'h000;
            torque_limit_o <= 10'h3FF;
            override_pct_o <= 8'h64;
            serial_422_en_o <= 1'b1;
            serial_232_en_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            phase_a_pos_o <= b_lags_a_now ? quad_q[0] : quad_q[1];
            phase_a_neg_o <= b_lags_a_now ? ~quad_q[0] : ~quad_q[1];
            phase_b_pos_o <= b_lags_a_now ? quad_q[1] : quad_q[0];
            phase_b_neg_o <= b_lags_a_now ? ~quad_q[1] : ~quad_q[0];
            zero_pulse_open_collector_b_o <= ~zero_pulse;
            zero_pulse_diff_pos_o <= zero_pulse; // same edge as open collector
            zero_pulse_diff_neg_o <= ~zero_pulse;
            monitor_out_one_o <= mon_pick(monsel_q[1:0], speed_code_i, torque_code_i,
                current_code_i, droop_code_i);
            monitor_out_two_o <= mon_pick(monsel_q[3:2], speed_code_i, torque_code_i,
                current_code_i, droop_code_i);
            // without availability the limit stays at full torque
            if (cfg_q[`EPE_CFG_TL_AVAIL] && ext_torque_limit_select_i)
                torque_limit_o <= analog_torque_limit_in_i; // 3FF = max torque
            else
                torque_limit_o <= 10'h3FF;
            // 100 + code*100/512, -512 -> 0, 0 -> 100, 511 -> ~200
            override_pct_o <= 8'h64 + ovr_scaled[7:0];
            serial_422_en_o <= ~cfg_q[`EPE_CFG_SERIAL_232];
            serial_232_en_o <= cfg_q[`EPE_CFG_SERIAL_232];
        end
    end

    // read decode; unmapped reads return zero
    always @*
    begin
        case (reg_addr_i)
            `EPE_IDX_PULSES: rdata_d = {16'h0, pulses_q};
            `EPE_IDX_CONFIG: rdata_d = {29'h0, cfg_q};
            `EPE_IDX_MONSEL: rdata_d = {28'h0, monsel_q};
            `EPE_IDX_POSITION: rdata_d = {{(32-POS_W){1'b0}}, pos_q};
            `EPE_IDX_STATUS: rdata_d = {28'h0, st_q, zero_pulse, quad_q};
            `EPE_IDX_TORQUE: rdata_d = {22'h0, torque_limit_o};
            `EPE_IDX_OVERRIDE: rdata_d = {24'h0, override_pct_o};
            `EPE_IDX_MONITOR: rdata_d = {6'h0, monitor_out_two_o, 6'h0, monitor_out_one_o};
            default: rdata_d = 32'h0;
        endcase
    end

    // read data stands one cycle after the strobe only
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            reg_rdata_o <= 32'h0;
        else if (clk_en_i)
            reg_rdata_o <= reg_rd_i ? rdata_d : 32'h0;
    end

endmodule

`default_nettype wire

// file: verif/epe_core_monitor.sv
// port assertions for the encoder pulse emulation core
`timescale 1ns/1ps
`default_nettype none

module epe_core_monitor #(
    parameter ZP_CYCLES = 20
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic clk_en_i,
    input wire logic rst_b_i,
    // watched inputs
    input wire logic ext_torque_limit_select_i,
    input wire logic signed [9:0] speed_override_in_i,
    // watched outputs
    input wire logic phase_a_pos_o,
    input wire logic phase_a_neg_o,
    input wire logic phase_b_pos_o,
    input wire logic phase_b_neg_o,
    input wire logic zero_pulse_open_collector_b_o,
    input wire logic zero_pulse_diff_pos_o,
    input wire logic zero_pulse_diff_neg_o,
    input wire logic [9:0] torque_limit_o,
    input wire logic [7:0] override_pct_o,
    input wire logic serial_422_en_o,
    input wire logic serial_232_en_o
);
    logic [31:0] low_q;
    logic signed [17:0] ov_prod;
    logic signed [17:0] ov_sh;
    logic [7:0] ov_exp;
    // expected override percentage, floor division by the shift
    assign ov_prod = speed_override_in_i * 18'sh64;
    assign ov_sh = ov_prod >>> 9;
    assign ov_exp = 8'h64 + ov_sh[7:0];
    // length of the current zero pulse, so a short pulse is caught on release
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            low_q <= 32'h0;
        else
            low_q <= zero_pulse_open_collector_b_o ? 32'h0 : low_q + 32'h1;
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_zp_diff; zero_pulse_diff_pos_o == !zero_pulse_open_collector_b_o; endproperty
    a_zp_diff: assert property (p_zp_diff) else $error("diff zero differs from open collector");
    property p_zp_neg; zero_pulse_diff_neg_o == !zero_pulse_diff_pos_o; endproperty
    a_zp_neg: assert property (p_zp_neg) else $error("diff zero pair not complementary");
    property p_a_comp; phase_a_neg_o == !phase_a_pos_o; endproperty
    a_a_comp: assert property (p_a_comp) else $error("phase a pair not complementary");
    property p_b_comp; phase_b_neg_o == !phase_b_pos_o; endproperty
    a_b_comp: assert property (p_b_comp) else $error("phase b pair not complementary");
    property p_serial; serial_422_en_o != serial_232_en_o; endproperty
    a_serial: assert property (p_serial) else $error("serial enables not exclusive");
    property p_zp_width; $rose(zero_pulse_open_collector_b_o) |-> low_q >= ZP_CYCLES; endproperty
    a_zp_width: assert property (p_zp_width) else $error("zero pulse too short");
    property p_tl_off; (clk_en_i && !ext_torque_limit_select_i) [*2] |-> torque_limit_o == 10'h3FF;
    endproperty
    a_tl_off: assert property (p_tl_off) else $error("torque limit applied while unselected");
    property p_ovr; (clk_en_i && $stable(speed_override_in_i)) [*2] |-> override_pct_o == ov_exp;
    endproperty
    a_ovr: assert property (p_ovr) else $error("override percentage wrong");
endmodule

bind epe_core epe_core_monitor #(.ZP_CYCLES(ZP_CYCLES)) u_mon (
    .sys_clk_i(sys_clk_i), .clk_en_i(clk_en_i), .rst_b_i(rst_b_i),
    .ext_torque_limit_select_i(ext_torque_limit_select_i), .speed_override_in_i(speed_override_in_i),
    .phase_a_pos_o(phase_a_pos_o), .phase_a_neg_o(phase_a_neg_o),
    .phase_b_pos_o(phase_b_pos_o), .phase_b_neg_o(phase_b_neg_o),
    .zero_pulse_open_collector_b_o(zero_pulse_open_collector_b_o),
    .zero_pulse_diff_pos_o(zero_pulse_diff_pos_o), .zero_pulse_diff_neg_o(zero_pulse_diff_neg_o),
    .torque_limit_o(torque_limit_o), .override_pct_o(override_pct_o),
    .serial_422_en_o(serial_422_en_o), .serial_232_en_o(serial_232_en_o));

`default_nettype wire

// file: verif/epe_qdec.sv
// quadrature counter standing in for the external position controller
`timescale 1ns/1ps
`default_nettype none

module epe_qdec (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // encoder phases and running count
    input wire logic a_i,
    input wire logic b_i,
    output var logic signed [15:0] count_o
);
    logic a_q;
    logic b_q;
    // up when b lags a, down when b leads; sampled, so edges must be a cycle apart
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            count_o <= 16'sh0;
        end
        else
        begin
            a_q <= a_i;
            b_q <= b_i;
            if ((a_i ^ a_q) | (b_i ^ b_q))
                count_o <= (a_q ^ b_i) ? count_o - 16'sh1 : count_o + 16'sh1;
        end
    end
endmodule

`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the encoder pulse emulation core
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct packed {logic [9:0] ovr; logic [7:0] pct; logic [3:0] msel;
        logic [9:0] m1; logic [9:0] m2;} epe_row_t;
    epe_row_t rows [4] = '{'{10'h200, 8'h00, 4'h4, 10'h011, 10'h022},
        '{10'h000, 8'h64, 4'hE, 10'h033, 10'h044}, '{10'h1FF, 8'hC7, 4'hB, 10'h044, 10'h033},
        '{10'h3FF, 8'h63, 4'h1, 10'h022, 10'h011}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic step = 1'b0;
    logic ccw = 1'b0;
    logic ext = 1'b0;
    logic ena = 1'b1;
    logic [9:0] atl = 10'h155;
    logic signed [9:0] ovr = 10'h000;
    logic [31:0] rdata;
    logic [9:0] mon1, mon2, tl;
    logic [7:0] pct;
    logic pa, pb, zoc, zp, s422, s232;
    logic pan, pbn, zpn;
    logic signed [15:0] cnt;
    int bad_count = 0;
    int num_checks = 0;
    int zeros = 0;
    int cyc = 0;
    int c0;

    always #4 clk = ~clk;

    epe_core #(.COUNTS_PER_REV(24'h000040), .ZP_CYCLES(20)) DUT (
        .sys_clk_i(clk), .clk_en_i(ena), .rst_b_i(rst_b),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .pos_step_i(step), .pos_dir_ccw_i(ccw),
        .speed_code_i(10'h011), .torque_code_i(10'h022), .current_code_i(10'h033),
        .droop_code_i(10'h044), .analog_torque_limit_in_i(atl), .speed_override_in_i(ovr),
        .ext_torque_limit_select_i(ext),
        .phase_a_pos_o(pa), .phase_a_neg_o(pan), .phase_b_pos_o(pb), .phase_b_neg_o(pbn),
        .zero_pulse_open_collector_b_o(zoc), .zero_pulse_diff_pos_o(zp), .zero_pulse_diff_neg_o(zpn),
        .monitor_out_one_o(mon1), .monitor_out_two_o(mon2), .torque_limit_o(tl),
        .override_pct_o(pct), .serial_422_en_o(s422), .serial_232_en_o(s232));

    epe_qdec u_qd (.sys_clk_i(clk), .rst_b_i(rst_b), .a_i(pa), .b_i(pb), .count_o(cnt));

    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rd_reg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask

    // lets registered outputs catch up after a write or a step
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task turn(input logic d, input int n);
        repeat (n)
        begin
            @(posedge clk);
            step <= 1'b1;
            ccw <= d;
            @(posedge clk);
            step <= 1'b0;
        end
        settle();
    endtask

    // a hang is cut short well past the expected run length
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    // zero pulses seen on the open collector output
    always @(negedge zoc)
        if (rst_b)
            zeros++;

    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 chk("zoc", 1, zoc);
        chk("s422", 1, s422);
        rd_reg(4'h0, 32'h00000FA0);
        rd_reg(4'hF, 32'h0);
        foreach (rows[i])
        begin
            wr_reg(4'h2, {28'h0, rows[i].msel});
            ovr <= rows[i].ovr;
            settle();
            chk("mon1", rows[i].m1, mon1);
            chk("mon2", rows[i].m2, mon2);
            chk("pct", rows[i].pct, pct);
        end
        @(posedge clk);
        ext <= 1'b1;
        wr_reg(4'h1, 32'h6);
        settle();
        chk("tl", 10'h155, tl);
        chk("s232", 1, s232);
        chk("s422", 0, s422);
        @(posedge clk);
        atl <= 10'h2AA;
        settle();
        chk("tl", 10'h2AA, tl);
        rd_reg(4'h5, 32'h000002AA);
        @(posedge clk);
        ext <= 1'b0;
        settle();
        chk("tl", 10'h3FF, tl);
        wr_reg(4'h1, 32'h0);
        settle();
        chk("tl", 10'h3FF, tl);
        chk("s422", 1, s422);
        wr_reg(4'h0, 32'h4);
        rd_reg(4'h0, 32'h00000004);
        c0 = cnt;
        turn(1'b1, 64);
        chk("count", c0 + 16, cnt);
        chk("zeros", 1, zeros);
        chk("zoc", 0, zoc);
        chk("zp", 1, zp);
        chk("zpn", 0, zpn);
        chk("pa", 0, pa);
        chk("pan", 1, pan);
        chk("pbn", 1, pbn);
        repeat (30) @(posedge clk);
        wr_reg(4'h1, 32'h1);
        settle();
        c0 = cnt;
        turn(1'b1, 64);
        chk("count", c0 - 16, cnt);
        chk("zeros", 2, zeros);
        repeat (30) @(posedge clk);
        c0 = cnt;
        turn(1'b0, 64);
        chk("count", c0 + 16, cnt);
        chk("zeros", 3, zeros);
        // low enable must freeze steps and register writes alike
        @(posedge clk);
        ena <= 1'b0;
        c0 = cnt;
        turn(1'b1, 8);
        wr_reg(4'h0, 32'h8);
        chk("count", c0, cnt);
        chk("zeros", 3, zeros);
        @(posedge clk);
        ena <= 1'b1;
        rd_reg(4'h0, 32'h00000004);
        // reset in mid-run brings every output back to its idle level
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("zoc", 1, zoc);
        chk("tl", 10'h3FF, tl);
        chk("pct", 8'h64, pct);
        chk("count", 0, cnt);
        @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(4'h0, 32'h00000FA0);
        rd_reg(4'h1, 32'h0);
        give_verdict();
    end
endmodule

`default_nettype wire
